/* File: mcsp_flag.sv */
// Purpose: bank of latched status flags cleared by a read
// Assumes: set and clear are one-cycle pulses on clk
// Notes: a set in the clearing cycle survives
`timescale 1ns/1ps
module mcsp_flag #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic soft_rst,
  input wire logic [W-1:0] set,
  input wire logic clr,
  output logic [W-1:0] flags
);
  // -----------------------------------------------------------------
  // one latch per bit
  // -----------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    // set wins over read clear and module reset
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        flags[i] <= 1'b0;
      end else if (set[i]) begin
        flags[i] <= 1'b1;
      end else if (clr || soft_rst) begin
        flags[i] <= 1'b0;
      end
    end
    AST_FLAG_LATCH: assert property (@(posedge clk) disable iff (sys_rst)
      set[i] |=> flags[i] [*2] or (flags[i] ##1 ($past(clr) || $past(soft_rst))))
      else $error("flag lost after set");
  end
endmodule

/* File: mcsp_host.sv */
// Purpose: two-wire host model driving clock and data
// Assumes: open-drain data line with pull-up
// Notes: phases of 8 clk, data moves 2 clk after clock fall
`timescale 1ns/1ps
module mcsp_host (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_rel
);
  // bus idles released
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // wait n edges
  task automatic hc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // start or repeated start, ends with clock low
  task automatic start();
    sda_rel <= 1'b1;
    hc(8);
    scl <= 1'b1;
    hc(8);
    sda_rel <= 1'b0;
    hc(8);
    scl <= 1'b0;
    hc(2);
  endtask
  // stop condition
  task automatic stop();
    sda_rel <= 1'b0;
    hc(8);
    scl <= 1'b1;
    hc(8);
    sda_rel <= 1'b1;
    hc(8);
  endtask
  // eight data bits then the acknowledge bit, msb first
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      sda_rel <= d[i];
      hc(8);
      scl <= 1'b1;
      hc(8);
      q[i] = sda_line;
      scl <= 1'b0;
      hc(2);
    end
  endtask
endmodule

/* File: mcsp_pkg.sv */
// Purpose: shared constants, carriers and states of the module control and status port
// Assumes: 10 MHz system clock
// Notes: offsets are byte addresses of the two-wire serial map
package mcsp_pkg;
  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CLK_MHZ = 10; // system clock rate in MHz
  localparam int T_RESET_MIN_NS = 2000; // least reset pulse, ns
  localparam int RESET_MIN_CYC = (T_RESET_MIN_NS * CLK_MHZ + 999) / 1000; // rounded up
  localparam int T_INIT_MS = 2000; // init interval, ms
  localparam int T_INIT_CYC = T_INIT_MS * CLK_MHZ * 1000; // init interval in cycles
  // -----------------------------------------------------------------
  // register map
  // -----------------------------------------------------------------
  localparam logic [7:0] REG_STATUS = 8'h02; // soft status, read only
  localparam logic [7:0] REG_LOS = 8'h03; // loss of signal flags, clear on read
  localparam logic [7:0] REG_FAULT = 8'h04; // transmit fault flags, clear on read
  localparam logic [7:0] REG_TXDIS = 8'h56; // transmit disable
  localparam logic [7:0] REG_LOS_MASK = 8'h64; // loss of signal masks
  localparam logic [7:0] REG_FAULT_MASK = 8'h65; // transmit fault masks
  localparam logic [7:0] REG_PAGE = 8'h7F; // upper page select
  localparam logic [7:0] REG_SQDIS = 8'hF0; // squelch disable, page 3
  localparam logic [7:0] REG_RXDIS = 8'hF1; // receive output disable, page 3
  localparam logic [7:0] UPPER_LIMIT = 8'h80; // first upper-page byte
  localparam logic [7:0] PAGE_CTRL = 8'h03; // page holding the lane controls
  localparam int STAT_DNR_BIT = 0; // data not ready
  localparam int STAT_ATTN_BIT = 1; // attention pin mirror
  localparam logic [7:0] CTRL_RST = 8'h00; // controls after reset, squelch on
  localparam logic [7:0] MASK_RST = 8'h00; // masks after reset
  localparam logic [7:0] PAGE_RST = 8'h00; // page after reset
  localparam logic [6:0] DEV_ADDR = 7'h50; // two-wire slave address
  // -----------------------------------------------------------------
  // carriers and states
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] rx_los; // receiver loss of signal, lanes 1-4
    logic [3:0] tx_los; // transmitter loss of signal
    logic [3:0] tx_fault; // transmitter fault condition
  } mcsp_lane_in_t;
  typedef struct packed {
    logic [3:0] tx_enable; // transmitter output on
    logic [3:0] rx_enable; // receiver output on
    logic [3:0] tx_squelch_en; // transmit squelch active
    logic [3:0] rx_squelch_en; // receive squelch active
  } mcsp_lane_out_t;
  localparam mcsp_lane_out_t LANE_OUT_RST = 16'hFFFF; // lane outputs after reset
  localparam logic [16:0] SYNC_RST = 17'h0000F; // synchroniser idle levels
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_WR, ST_ACK_WR, ST_RD, ST_ACK_RD
  } mcsp_tw_state_t;
endpackage

/* File: mcsp_sync.sv */
// Purpose: two-flop synchroniser for asynchronous pins
// Assumes: inputs come from outside the clock domain
// Notes: only the second stage is visible
`timescale 1ns/1ps
module mcsp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta; // first stage, read by the second only
  // -----------------------------------------------------------------
  // two stages
  // -----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

/* File: mcsp_top.sv */
// Purpose: control and status port of a four-lane pluggable module
// Assumes: host drives select, reset, low power and the two-wire bus
// Notes: lane controls are volatile, cleared by any reset
// Operation
// - take part in bus only while selected
// - deselected module never acknowledges bus traffic
// - undriven select input reads as deselected
// - long reset pulse restores every default
// - init interval starts at reset release
// - completion shown by attention, data ready
// - power-up posts completion without reset pulse
// - low power input works except 1.5W class
// - presence output tied low
// - attention is open-drain active-low fault indicator
// - attention state mirrored at byte 2 bit 1
// - loss of signal flags latched, read clears
// - transmit fault flags latched, read clears
// - transmit fault disables that lane's output
// - reset or disable toggle clears fault
// - transmit disable bits in byte 86
// - receive output disable in byte 241
// - squelch disable in byte 240, default on
// - volatile per-lane controls, masks gate attention
// - attention released soon after flag cleared
`timescale 1ns/1ps
module mcsp_top import mcsp_pkg::*; #(
  parameter int INIT_CYCLES = T_INIT_CYC, // init interval, cycles
  parameter logic CLASS_1W5 = 1'b1 // module belongs to the 1.5W class
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic bus_select_n,
  input wire logic bus_select_drive,
  input wire logic module_reset_n,
  input wire logic low_power_request,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire mcsp_lane_in_t lane_status,
  output mcsp_lane_out_t lane_ctrl,
  output logic low_power_active,
  output logic presence_n,
  output logic attention_out,
  output logic attention_oe
);
  localparam int ICW = $clog2(INIT_CYCLES + 1); // init counter width
  localparam int RCW = $clog2(RESET_MIN_CYC + 2); // reset pulse counter width
  localparam logic [RCW-1:0] RST_ARMED = RCW'(RESET_MIN_CYC + 1); // strictly longer than least
  // -----------------------------------------------------------------
  // decode shared by read and write
  // -----------------------------------------------------------------
  function automatic logic mcsp_hit(input logic [7:0] addr, input logic [7:0] page, input logic [7:0] off);
    mcsp_hit = (addr == off) && ((addr < UPPER_LIMIT) || (page == PAGE_CTRL));
  endfunction
  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  logic sel_pin; // select level after the internal bias
  logic [16:0] sync_out; // synchronised pins
  logic scl_s, sda_s, sel_s, rst_n_s, lp_s; // synchronised controls
  mcsp_lane_in_t lane_s; // synchronised lane conditions
  // an undriven select floats to the deselected level
  assign sel_pin = bus_select_drive ? bus_select_n : 1'b1;
  mcsp_sync #(.W(17), .RST_VAL(SYNC_RST)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d({lane_status, low_power_request, module_reset_n, sel_pin, sda_in, scl}),
    .q(sync_out)
  );
  assign {lane_s, lp_s, rst_n_s, sel_s, sda_s, scl_s} = sync_out;
  logic scl_d, sda_d, rst_n_d; // previous samples for edges
  // edge history
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      rst_n_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      rst_n_d <= rst_n_s;
    end
  end
  logic scl_rise, scl_fall, bus_start, bus_stop, sel_act; // bus events
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign bus_start = scl_s && scl_d && sda_d && !sda_s;
  assign bus_stop = scl_s && scl_d && !sda_d && sda_s;
  assign sel_act = !sel_s;
  // -----------------------------------------------------------------
  // module reset pin and init interval
  // -----------------------------------------------------------------
  logic [RCW-1:0] rst_low_cnt; // length of current low level
  logic soft_rst; // one-cycle module reset
  // count low time, fire reset at the releasing edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_low_cnt <= '0;
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= rst_n_s && !rst_n_d && (rst_low_cnt == RST_ARMED);
      if (!rst_n_s) begin
        if (rst_low_cnt != RST_ARMED) begin
          rst_low_cnt <= rst_low_cnt + 1'b1;
        end
      end else begin
        rst_low_cnt <= '0;
      end
    end
  end
  logic [ICW-1:0] init_cnt; // cycles into init interval
  logic init_busy; // data not ready
  logic reset_done; // completion event, sticky
  logic done_clr; // read of status byte
  // init runs from power-up and from each module reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      init_busy <= 1'b1;
      init_cnt <= '0;
      reset_done <= 1'b0;
    end else if (soft_rst) begin
      init_busy <= 1'b1;
      init_cnt <= '0;
      reset_done <= 1'b0;
    end else if (init_busy) begin
      if (init_cnt == ICW'(INIT_CYCLES - 1)) begin
        init_busy <= 1'b0;
        reset_done <= 1'b1;
      end else begin
        init_cnt <= init_cnt + 1'b1;
      end
    end else if (done_clr) begin
      reset_done <= 1'b0;
    end
  end
  // -----------------------------------------------------------------
  // two-wire slave
  // -----------------------------------------------------------------
  mcsp_tw_state_t state; // bus state
  logic [3:0] bit_cnt; // bits in current byte
  logic [7:0] shreg; // shift register
  logic [7:0] ptr; // byte pointer
  logic rw; // read transfer
  logic first_byte; // next write byte is the pointer
  logic nack; // host refused more data
  logic load_rd; // fetch a byte for the host
  logic wr_stb; // store a byte
  logic [7:0] rd_data; // addressed byte
  logic [7:0] page; // upper page
  assign load_rd = sel_act && !bus_start && !bus_stop && scl_fall &&
    (((state == ST_ACK_ADDR) && rw) || ((state == ST_ACK_RD) && !nack));
  assign wr_stb = sel_act && !bus_start && !bus_stop && scl_fall &&
    (state == ST_WR) && (bit_cnt == 4'h8) && !first_byte;
  // bus sequencer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      ptr <= 8'h00;
      rw <= 1'b0;
      first_byte <= 1'b0;
      nack <= 1'b0;
      sda_oe <= 1'b0;
    end else if (!sel_act) begin
      state <= ST_IDLE;
      sda_oe <= 1'b0;
    end else if (bus_start) begin
      state <= ST_ADDR;
      bit_cnt <= 4'h0;
      sda_oe <= 1'b0;
    end else if (bus_stop) begin
      state <= ST_IDLE;
      sda_oe <= 1'b0;
    end else if (scl_rise) begin
      case (state)
        ST_ADDR, ST_WR: begin
          shreg <= {shreg[6:0], sda_s};
          bit_cnt <= bit_cnt + 4'h1;
        end
        ST_RD: begin
          bit_cnt <= bit_cnt + 4'h1;
        end
        ST_ACK_RD: begin
          nack <= sda_s;
        end
        default: begin
        end
      endcase
    end else if (load_rd) begin
      shreg <= rd_data;
      sda_oe <= !rd_data[7];
      bit_cnt <= 4'h0;
      ptr <= ptr + 8'h01;
      state <= ST_RD;
    end else if (scl_fall) begin
      case (state)
        ST_ADDR: begin
          if (bit_cnt == 4'h8) begin
            if (shreg[7:1] == DEV_ADDR) begin
              state <= ST_ACK_ADDR;
              sda_oe <= 1'b1;
              rw <= shreg[0];
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_ACK_ADDR: begin
          state <= ST_WR;
          sda_oe <= 1'b0;
          bit_cnt <= 4'h0;
          first_byte <= 1'b1;
        end
        ST_WR: begin
          if (bit_cnt == 4'h8) begin
            state <= ST_ACK_WR;
            sda_oe <= 1'b1;
            first_byte <= 1'b0;
            ptr <= first_byte ? shreg : ptr + 8'h01;
          end
        end
        ST_ACK_WR: begin
          state <= ST_WR;
          sda_oe <= 1'b0;
          bit_cnt <= 4'h0;
        end
        ST_RD: begin
          if (bit_cnt == 4'h8) begin
            state <= ST_ACK_RD;
            sda_oe <= 1'b0;
          end else begin
            shreg <= {shreg[6:0], 1'b0};
            sda_oe <= !shreg[6];
          end
        end
        ST_ACK_RD: begin
          state <= ST_IDLE; // host refused further bytes
          sda_oe <= 1'b0;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
  assign sda_out = 1'b0;
  // -----------------------------------------------------------------
  // register file
  // -----------------------------------------------------------------
  logic [3:0] tx_dis, tx_dis_d, rx_dis; // lane disables
  logic [7:0] sq_dis; // squelch disables, tx low nibble
  logic [7:0] los_mask; // loss of signal masks
  logic [3:0] fault_mask; // fault masks
  logic [7:0] los_flags; // latched loss of signal
  logic [3:0] fault_flags; // latched faults
  logic [3:0] fault_state; // lanes held off by fault
  logic attention_q; // attention asserted
  logic los_clr, fault_clr; // read clears
  // volatile controls, cleared by both resets
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_dis <= CTRL_RST[3:0];
      rx_dis <= CTRL_RST[7:4];
      sq_dis <= CTRL_RST;
      los_mask <= MASK_RST;
      fault_mask <= MASK_RST[3:0];
      page <= PAGE_RST;
    end else if (soft_rst) begin
      tx_dis <= CTRL_RST[3:0];
      rx_dis <= CTRL_RST[7:4];
      sq_dis <= CTRL_RST;
      los_mask <= MASK_RST;
      fault_mask <= MASK_RST[3:0];
      page <= PAGE_RST;
    end else if (wr_stb) begin
      if (mcsp_hit(ptr, page, REG_TXDIS)) tx_dis <= shreg[3:0];
      if (mcsp_hit(ptr, page, REG_RXDIS)) rx_dis <= shreg[7:4];
      if (mcsp_hit(ptr, page, REG_SQDIS)) sq_dis <= shreg;
      if (mcsp_hit(ptr, page, REG_LOS_MASK)) los_mask <= shreg;
      if (mcsp_hit(ptr, page, REG_FAULT_MASK)) fault_mask <= shreg[3:0];
      if (mcsp_hit(ptr, page, REG_PAGE)) page <= shreg;
    end
  end
  // read mux, unmapped bytes read zero
  always_comb begin
    rd_data = 8'h00;
    if (mcsp_hit(ptr, page, REG_STATUS)) begin
      rd_data[STAT_ATTN_BIT] = !attention_q;
      rd_data[STAT_DNR_BIT] = init_busy;
    end
    if (mcsp_hit(ptr, page, REG_LOS)) rd_data = los_flags;
    if (mcsp_hit(ptr, page, REG_FAULT)) rd_data = {4'h0, fault_flags};
    if (mcsp_hit(ptr, page, REG_TXDIS)) rd_data = {4'h0, tx_dis};
    if (mcsp_hit(ptr, page, REG_RXDIS)) rd_data = {rx_dis, 4'h0};
    if (mcsp_hit(ptr, page, REG_SQDIS)) rd_data = sq_dis;
    if (mcsp_hit(ptr, page, REG_LOS_MASK)) rd_data = los_mask;
    if (mcsp_hit(ptr, page, REG_FAULT_MASK)) rd_data = {4'h0, fault_mask};
    if (mcsp_hit(ptr, page, REG_PAGE)) rd_data = page;
  end
  assign los_clr = load_rd && mcsp_hit(ptr, page, REG_LOS);
  assign fault_clr = load_rd && mcsp_hit(ptr, page, REG_FAULT);
  assign done_clr = load_rd && mcsp_hit(ptr, page, REG_STATUS);
  mcsp_flag #(.W(8)) u_los (
    .clk(clk),
    .sys_rst(sys_rst),
    .soft_rst(soft_rst),
    .set({lane_s.tx_los, lane_s.rx_los}),
    .clr(los_clr),
    .flags(los_flags)
  );
  mcsp_flag #(.W(4)) u_fault (
    .clk(clk),
    .sys_rst(sys_rst),
    .soft_rst(soft_rst),
    .set(lane_s.tx_fault),
    .clr(fault_clr),
    .flags(fault_flags)
  );
  // -----------------------------------------------------------------
  // lane fault hold and lane outputs
  // -----------------------------------------------------------------
  for (genvar i = 0; i < 4; i++) begin : g_fault
    // persistent fault wins over reset and disable toggle
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        fault_state[i] <= 1'b0;
      end else if (lane_s.tx_fault[i]) begin
        fault_state[i] <= 1'b1;
      end else if (soft_rst || (tx_dis[i] != tx_dis_d[i])) begin
        fault_state[i] <= 1'b0;
      end
    end
  end
  // lane output drive and disable history
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_dis_d <= CTRL_RST[3:0];
      lane_ctrl <= LANE_OUT_RST;
      low_power_active <= 1'b0;
    end else begin
      tx_dis_d <= tx_dis;
      lane_ctrl.tx_enable <= ~tx_dis & ~fault_state;
      lane_ctrl.rx_enable <= ~rx_dis;
      lane_ctrl.tx_squelch_en <= ~sq_dis[3:0];
      lane_ctrl.rx_squelch_en <= ~sq_dis[7:4];
      low_power_active <= lp_s && !CLASS_1W5;
    end
  end
  // -----------------------------------------------------------------
  // attention output and presence
  // -----------------------------------------------------------------
  logic any_src; // unmasked latched source present
  assign any_src = (|(los_flags & ~los_mask)) || (|(fault_flags & ~fault_mask)) || reset_done;
  // attention follows its sources, released once all clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      attention_q <= 1'b0;
    end else begin
      attention_q <= any_src;
    end
  end
  assign attention_out = 1'b0;
  assign attention_oe = attention_q;
  assign presence_n = 1'b0;
  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_NO_ACK_DESELECTED: assert property ($past(sel_s) && sel_s |-> !sda_oe)
    else $error("bus driven while deselected");
  AST_ACK_SELECTED: assert property ($rose(sda_oe) |-> !$past(sel_s))
    else $error("bus driven without select");
  AST_BIAS_HIGH: assert property ((!bus_select_drive) [*3] |-> sel_s && !sel_act)
    else $error("floating select not deselected");
  AST_RESET_DEFAULTS: assert property (soft_rst |=> tx_dis == 4'h0 && sq_dis == 8'h00 && los_mask == 8'h00)
    else $error("module reset left settings");
  AST_INIT_START: assert property (soft_rst |=> init_busy && init_cnt == '0 && !reset_done)
    else $error("init did not restart");
  AST_DONE_POST: assert property ($rose(reset_done) |-> !init_busy ##1 attention_q && !init_busy)
    else $error("completion not posted");
  AST_INIT_END: assert property (init_busy && init_cnt == ICW'(INIT_CYCLES - 1) && !soft_rst |=> reset_done ##1 attention_q)
    else $error("init end missing");
  AST_LOW_POWER: assert property (##1 low_power_active == ($past(lp_s) && !CLASS_1W5))
    else $error("low power wrong");
  AST_FAULT_OFF: assert property (lane_s.tx_fault != 4'h0 |-> ##2 (lane_ctrl.tx_enable & $past(lane_s.tx_fault, 2)) == 4'h0)
    else $error("faulted lane still on");
  AST_FAULT_PERSIST: assert property (soft_rst |=> (fault_state & $past(lane_s.tx_fault)) == $past(lane_s.tx_fault))
    else $error("persistent fault cleared");
  AST_ATTN_RELEASE: assert property ((!any_src) [*2] |-> !attention_oe)
    else $error("attention not released");
  AST_ATTN_HOLD: assert property (any_src [*2] |-> attention_oe && !attention_out)
    else $error("attention dropped early");
  COV_WRITE: cover property (wr_stb && mcsp_hit(ptr, page, REG_TXDIS));
  COV_READ_CLEAR: cover property (los_clr ##[1:20] !attention_oe);
  COV_DONE: cover property ($rose(reset_done));
  COV_FAULT_RESTORE: cover property ($fell(fault_state[1]) ##[1:1000] lane_ctrl.tx_enable[1]);
endmodule

/* File: tb.sv */
// Purpose: register and pin tests of the control and status port
// Assumes: short init interval of 50 cycles
// Notes: host model reached through its tasks
`timescale 1ns/1ps
module tb import mcsp_pkg::*;;
  logic clk, sys_rst, sel_n, sel_drv, mrst_n, lpm, scl, sda_rel, sda_oe, sda_out, lpa, prs_n, att_out, att_oe, ack;
  mcsp_lane_in_t ls;
  mcsp_lane_out_t lc;
  logic [8:0] q;
  logic [7:0] v;
  int err_total, n_compared;
  wire sda_line = sda_rel & ~sda_oe; // wired-and with pull-up
  mcsp_top #(.INIT_CYCLES(50)) u_mcsp_top (.clk(clk), .sys_rst(sys_rst), .bus_select_n(sel_n),
    .bus_select_drive(sel_drv), .module_reset_n(mrst_n), .low_power_request(lpm), .scl(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .lane_status(ls), .lane_ctrl(lc),
    .low_power_active(lpa), .presence_n(prs_n), .attention_out(att_out), .attention_oe(att_oe));
  mcsp_host u_mcsp_host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_rel(sda_rel));
  // compare and count
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one register access: write wd, or read into rv
  task automatic acc(input bit rnw, input logic [7:0] a, input logic [7:0] wd, output logic [7:0] rv);
    u_mcsp_host.start();
    u_mcsp_host.xfer({DEV_ADDR, 2'b01}, q);
    ack = q[0];
    u_mcsp_host.xfer({a, 1'b1}, q);
    if (rnw) begin
      u_mcsp_host.start();
      u_mcsp_host.xfer({DEV_ADDR, 2'b11}, q);
      u_mcsp_host.xfer(9'h1FF, q);
      rv = q[8:1];
    end else begin
      u_mcsp_host.xfer({wd, 1'b1}, q);
    end
    u_mcsp_host.stop();
  endtask
  // read and compare
  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
    acc(1'b1, a, 8'h00, v);
    chk(nm, e, v);
  endtask
  // verdict
  task automatic test_done();
    $display("mismatches %0d compares %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // hang guard
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    test_done();
  end
  // main sequence
  initial begin
    {sys_rst, sel_n, sel_drv, mrst_n, lpm} = 5'h1F;
    ls = '0;
    err_total = 0;
    n_compared = 0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    sel_n <= 1'b0;
    repeat (10) @(posedge clk);
    chk("lane_ctrl", LANE_OUT_RST, lc);
    chk("presence_n", 16'h0, prs_n);
    chk("low_power_active", 16'h0, lpa);
    chk("attention_oe", 16'h0, att_oe);
    chk("attention_out", 16'h0, att_out);
    chk("sda_out", 16'h0, sda_out);
    repeat (60) @(posedge clk);
    chk("attention_oe", 16'h1, att_oe);
    rdc("status", REG_STATUS, 8'h00);
    chk("attention_oe", 16'h0, att_oe);
    rdc("status", REG_STATUS, 8'h02);
    sel_n <= 1'b1;
    repeat (10) @(posedge clk);
    acc(1'b0, REG_TXDIS, 8'h0F, v);
    chk("ack", 16'h1, ack);
    chk("lane_ctrl", LANE_OUT_RST, lc);
    {sel_n, sel_drv} <= 2'b00;
    repeat (10) @(posedge clk);
    acc(1'b0, REG_TXDIS, 8'h0F, v);
    chk("ack", 16'h1, ack);
    sel_drv <= 1'b1;
    repeat (10) @(posedge clk);
    acc(1'b0, REG_TXDIS, 8'h05, v);
    chk("ack", 16'h0, ack);
    chk("tx_enable", 16'hA, lc.tx_enable);
    rdc("tx_disable", REG_TXDIS, 8'h05);
    rdc("unmapped", 8'h10, 8'h00);
    acc(1'b0, REG_PAGE, PAGE_CTRL, v);
    acc(1'b0, REG_SQDIS, 8'h21, v);
    acc(1'b0, REG_RXDIS, 8'h30, v);
    chk("lane_ctrl", 16'hACED, lc);
    ls.rx_los <= 4'h2;
    repeat (10) @(posedge clk);
    ls <= '0;
    repeat (5) @(posedge clk);
    chk("attention_oe", 16'h1, att_oe);
    rdc("los", REG_LOS, 8'h02);
    chk("attention_oe", 16'h0, att_oe);
    rdc("los", REG_LOS, 8'h00);
    acc(1'b0, REG_LOS_MASK, 8'hFF, v);
    ls.tx_los <= 4'h1;
    repeat (10) @(posedge clk);
    ls <= '0;
    repeat (5) @(posedge clk);
    chk("attention_oe", 16'h0, att_oe);
    rdc("los", REG_LOS, 8'h10);
    ls.tx_fault <= 4'h2;
    repeat (10) @(posedge clk);
    chk("tx_enable", 4'h8, lc.tx_enable);
    ls <= '0;
    repeat (5) @(posedge clk);
    chk("attention_oe", 16'h1, att_oe);
    rdc("fault", REG_FAULT, 8'h02);
    chk("tx_enable", 4'h8, lc.tx_enable);
    acc(1'b0, REG_TXDIS, 8'h07, v);
    acc(1'b0, REG_TXDIS, 8'h05, v);
    chk("tx_enable", 16'hA, lc.tx_enable);
    mrst_n <= 1'b0;
    repeat (5) @(posedge clk);
    mrst_n <= 1'b1;
    repeat (10) @(posedge clk);
    chk("tx_enable", 16'hA, lc.tx_enable);
    mrst_n <= 1'b0;
    repeat (30) @(posedge clk);
    mrst_n <= 1'b1;
    repeat (10) @(posedge clk);
    chk("lane_ctrl", LANE_OUT_RST, lc);
    chk("attention_oe", 16'h0, att_oe);
    repeat (60) @(posedge clk);
    chk("attention_oe", 16'h1, att_oe);
    rdc("status", REG_STATUS, 8'h00);
    test_done();
  end
endmodule
